// file: rtl/updown_timer_defs.vh
// Contract
// - 11-bit counter, direction chosen by control bit
// - free-running raises interrupt on reaching zero
// - clock from system or low-power clock
// - interrupt on reaching zero or reload threshold
// - two channels, rising or falling edge select
// - counting mode stores cycles after edge count
// - counting mode restarts next group until disabled
// - capture snapshots own count or 22-bit clock
// - pending event discards snapshot, sets overrun flag
// - overrun clears together with event flag
// - both channels may share one input pin
// - count-enable zero capture, one counting mode
// - per-channel interrupt enable gates channel interrupt
// - per-channel snapshot source: clock or count
// - pin select values 1..12 map pins 0..11
// - captured value readable in channel value register
// - writing one to clear bit clears event
// - period field gives input periods plus one
// - counted value equals timer cycles over periods
// - programmable reload value used as threshold
// - counting needs both clock gate and enable
`ifndef UPDOWN_TIMER_DEFS_VH
`define UPDOWN_TIMER_DEFS_VH

// widths
`define CNT_W        11
`define RTC_W        22
`define PIN_N        12
`define PSEL_W       4
`define PER_W        8
`define CHAN_N       2

// counter constants
`define CNT_ZERO     11'h000
`define CNT_ONE      11'h001
`define CNT_MAX      11'h7FF

// pin select decode
`define PSEL_FIRST   4'h1
`define PSEL_LAST    4'hC

// snapshot and mode encodings
`define SNAP_RTC     1'b1
`define MODE_COUNT   1'b1

// channel counters
`define CYC_ZERO     22'h000000
`define CYC_ONE      22'h000001
`define PER_ZERO     8'h00
`define PER_ONE      8'h01

// synchroniser reset level
`define SYNC_RST     3'h0

`endif

// file: rtl/updown_timer_with_capture.v
`include "updown_timer_defs.vh"

module updown_timer_with_capture
(
    // clock and reset
    input  wire                          core_clk,
    input  wire                          nrst,
    // timer control
    input  wire                          clockSourceFastSel,
    input  wire                          freeRunningEnable,
    input  wire                          counterIrqEnable,
    input  wire                          downwardDirectionEnable,
    input  wire [`CNT_W-1:0]             reloadThreshold,
    input  wire                          counterClockGate,
    input  wire                          counterRunEnable,
    // external sources
    input  wire                          lowPowerClock,
    input  wire [`PIN_N-1:0]             gpioPins,
    input  wire [`RTC_W-1:0]             rtcValue,
    // channel control, channel 0 in low bits
    input  wire [`CHAN_N-1:0]            channelFallingEdgeSel,
    input  wire [`CHAN_N-1:0]            channelCountingModeSel,
    input  wire [`CHAN_N-1:0]            channelIrqEnable,
    input  wire [`CHAN_N-1:0]            channelSnapshotSource,
    input  wire [`CHAN_N*`PSEL_W-1:0]    channelInputPinSel,
    input  wire [`CHAN_N*`PER_W-1:0]     channelPeriodCount,
    input  wire [`CHAN_N-1:0]            channelEventClear,
    // timer status
    output wire [`CNT_W-1:0]             counterValue,
    output wire                          timerIrq,
    // channel status
    output wire [`CHAN_N*`RTC_W-1:0]     channelCapturedValue,
    output wire [`CHAN_N-1:0]            channelEventFlag,
    output wire [`CHAN_N-1:0]            channelCaptureOverrun,
    output wire [`CHAN_N-1:0]            channelIrq
);

    // low-power clock synchroniser and edge detect
    reg  [2:0]          lpSync_q;
    reg                 lpLevel_q;
    wire                lpAgree;
    wire                lpRise;

    // pin synchronisers
    reg  [`PIN_N-1:0]   pinS1_q;
    reg  [`PIN_N-1:0]   pinS2_q;
    reg  [`PIN_N-1:0]   pinS3_q;
    reg  [`PIN_N-1:0]   pinLevel_q;

    // counter state
    reg  [`CNT_W-1:0]   count_q;
    reg  [`CNT_W-1:0]   count_d;
    reg                 timerIrq_q;
    reg                 hit;
    wire                tick;
    wire                running;
    wire                step;

    // low-power clock sampled through three flops
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lpSync_q  <= `SYNC_RST;
            lpLevel_q <= 1'b0;
        end
        else
        begin
            lpSync_q <= {lpSync_q[1:0], lowPowerClock};
            if (lpAgree)
            begin
                lpLevel_q <= lpSync_q[1];
            end
        end
    end

    // a change counts once second and third stage agree
    assign lpAgree = (lpSync_q[1] == lpSync_q[2]);
    assign lpRise  = lpAgree & lpSync_q[1] & ~lpLevel_q;

    // timer tick from fast or low-power source
    assign tick    = clockSourceFastSel ? 1'b1 : lpRise;
    assign running = counterRunEnable & counterClockGate;
    assign step    = running & tick;

    // gpio pins sampled through three flops
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pinS1_q    <= {`PIN_N{1'b0}};
            pinS2_q    <= {`PIN_N{1'b0}};
            pinS3_q    <= {`PIN_N{1'b0}};
            pinLevel_q <= {`PIN_N{1'b0}};
        end
        else
        begin
            pinS1_q    <= gpioPins;
            pinS2_q    <= pinS1_q;
            pinS3_q    <= pinS2_q;
            // take stage two only where it matches stage three
            pinLevel_q <= (pinS2_q & ~(pinS2_q ^ pinS3_q))
                        | (pinLevel_q & (pinS2_q ^ pinS3_q));
        end
    end

    // next count and threshold hit
    always @*
    begin
        count_d = count_q;
        hit     = 1'b0;
        if (downwardDirectionEnable)
        begin
            // down: reload after zero, hit on reaching zero
            if (count_q == `CNT_ZERO)
            begin
                count_d = reloadThreshold;
            end
            else
            begin
                count_d = count_q - `CNT_ONE;
            end
            hit = (count_d == `CNT_ZERO);
        end
        else if (freeRunningEnable)
        begin
            // free-running up: wraps past maximum to zero
            count_d = count_q + `CNT_ONE;
            hit     = (count_d == `CNT_ZERO);
        end
        else
        begin
            // up: restart from zero after reload value
            if (count_q == reloadThreshold)
            begin
                count_d = `CNT_ZERO;
            end
            else
            begin
                count_d = count_q + `CNT_ONE;
            end
            hit = (count_d == reloadThreshold);
        end
    end

    // counter register and timer interrupt pulse
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count_q    <= `CNT_ZERO;
            timerIrq_q <= 1'b0;
        end
        else if (!counterRunEnable)
        begin
            // idle: preset to the start point of the direction
            count_q    <= downwardDirectionEnable ? reloadThreshold : `CNT_ZERO;
            timerIrq_q <= 1'b0;
        end
        else
        begin
            if (step)
            begin
                count_q <= count_d;
            end
            timerIrq_q <= step & hit & counterIrqEnable;
        end
    end

    assign counterValue = count_q;
    assign timerIrq     = timerIrq_q;

    // sense channels
    genvar ch;
    generate
        for (ch = 0; ch < `CHAN_N; ch = ch + 1)
        begin : chan
            wire [`PSEL_W-1:0] pinSel;
            wire [`PSEL_W-1:0] pinIdx;
            wire [`PER_W-1:0]  periodCount;
            wire               selValid;
            wire               selLevel;
            wire               edgeSeen;
            wire               groupDone;
            wire               capEvent;
            wire               clearReq;
            reg                level_q;
            reg                valid_q;
            reg  [`RTC_W-1:0]  cycles_q;
            reg  [`PER_W-1:0]  edges_q;
            reg  [`RTC_W-1:0]  value_q;
            reg                event_q;
            reg                overrun_q;

            // pin select: 1..12 picks pin 0..11, else none
            assign pinSel   = channelInputPinSel[ch*`PSEL_W +: `PSEL_W];
            assign pinIdx   = pinSel - `PSEL_FIRST;
            assign selValid = (pinSel >= `PSEL_FIRST) && (pinSel <= `PSEL_LAST);
            assign selLevel = selValid & pinLevel_q[pinIdx];

            assign periodCount = channelPeriodCount[ch*`PER_W +: `PER_W];
            assign clearReq    = channelEventClear[ch];

            // edge of chosen polarity on the selected pin
            assign edgeSeen = valid_q & counterRunEnable
                            & (channelFallingEdgeSel[ch] ? (level_q & ~selLevel)
                                                         : (~level_q & selLevel));

            // counting mode finishes after period field plus one edges
            assign groupDone = edgeSeen & (channelCountingModeSel[ch] == `MODE_COUNT)
                             & (edges_q == periodCount);

            // a capture or a finished edge group is the channel event
            assign capEvent = groupDone
                            | (edgeSeen & (channelCountingModeSel[ch] != `MODE_COUNT));

            // remembered level for edge detection
            always @(posedge core_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    level_q <= 1'b0;
                    valid_q <= 1'b0;
                end
                else
                begin
                    level_q <= selLevel;
                    valid_q <= selValid;
                end
            end

            // cycle and edge counters for counting mode
            always @(posedge core_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    cycles_q <= `CYC_ZERO;
                    edges_q  <= `PER_ZERO;
                end
                else if (!counterRunEnable || channelCountingModeSel[ch] != `MODE_COUNT)
                begin
                    cycles_q <= `CYC_ZERO;
                    edges_q  <= `PER_ZERO;
                end
                else if (groupDone)
                begin
                    // next group starts at once
                    cycles_q <= step ? `CYC_ONE : `CYC_ZERO;
                    edges_q  <= `PER_ZERO;
                end
                else
                begin
                    if (step)
                    begin
                        cycles_q <= cycles_q + `CYC_ONE;
                    end
                    if (edgeSeen)
                    begin
                        edges_q <= edges_q + `PER_ONE;
                    end
                end
            end

            // captured value, event and overrun flags
            always @(posedge core_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    value_q   <= `CYC_ZERO;
                    event_q   <= 1'b0;
                    overrun_q <= 1'b0;
                end
                else
                begin
                    if (capEvent && !event_q)
                    begin
                        if (groupDone)
                        begin
                            value_q <= cycles_q;
                        end
                        else if (channelSnapshotSource[ch] == `SNAP_RTC)
                        begin
                            value_q <= rtcValue;
                        end
                        else
                        begin
                            value_q <= {{(`RTC_W-`CNT_W){1'b0}}, count_q};
                        end
                    end
                    // set wins over a clear in the same cycle
                    if (capEvent)
                    begin
                        event_q <= 1'b1;
                    end
                    else if (clearReq)
                    begin
                        event_q <= 1'b0;
                    end
                    if (capEvent && event_q)
                    begin
                        overrun_q <= 1'b1;
                    end
                    else if (clearReq)
                    begin
                        overrun_q <= 1'b0;
                    end
                end
            end

            assign channelCapturedValue[ch*`RTC_W +: `RTC_W] = value_q;
            assign channelEventFlag[ch]      = event_q;
            assign channelCaptureOverrun[ch] = overrun_q;
            assign channelIrq[ch]            = event_q & channelIrqEnable[ch];
        end
    endgenerate

endmodule

// file: tb/pin_rtc_model.sv
module pin_rtc_model (
    // shared clock
    input  wire         core_clk,
    // far side outputs
    output logic [11:0] gpioPins,
    output logic [21:0] rtcValue,
    output wire         lowPowerClock
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] div = 4'h0;
    logic       rtcRun = 1'b1;
    logic       waveOn = 1'b0;
    int         wavePin = 0;
    // slow clock at an eighth of the core clock
    assign lowPowerClock = div[2];
    initial gpioPins = 12'h000;
    initial rtcValue = 22'h000000;
    // rtc runs unless frozen, square wave toggles every 8 cycles
    always @(posedge core_clk)
    begin
        div <= div + 4'h1;
        if (rtcRun)
            rtcValue <= rtcValue + 22'h000001;
        if (waveOn && div[2:0] == 3'h7)
            gpioPins[wavePin] <= ~gpioPins[wavePin];
    end
    // move one pin and hold it past the input filter
    task automatic set_pin(input int p, input logic v);
        gpioPins[p] <= v;
        repeat (8) @(posedge core_clk);
    endtask
endmodule

// file: tb/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LP_DIV = 8;
    localparam int WAVE_P = 16;
    localparam int WRAP = 2048;
    // driven inputs
    logic        core_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        clockSourceFastSel = 1'b1;
    logic        freeRunningEnable = 1'b0;
    logic        counterIrqEnable = 1'b1;
    logic        downwardDirectionEnable = 1'b0;
    logic [10:0] reloadThreshold = 11'h004;
    logic        counterClockGate = 1'b1;
    logic        counterRunEnable = 1'b0;
    logic [1:0]  channelFallingEdgeSel = 2'h0;
    logic [1:0]  channelCountingModeSel = 2'h0;
    logic [1:0]  channelIrqEnable = 2'h0;
    logic [1:0]  channelSnapshotSource = 2'h0;
    logic [7:0]  channelInputPinSel = 8'h00;
    logic [15:0] channelPeriodCount = 16'h0000;
    logic [1:0]  channelEventClear = 2'h0;
    // observed signals
    wire         lowPowerClock;
    wire  [11:0] gpioPins;
    wire  [21:0] rtcValue;
    wire  [10:0] counterValue;
    wire         timerIrq;
    wire  [43:0] channelCapturedValue;
    wire  [1:0]  channelEventFlag;
    wire  [1:0]  channelCaptureOverrun;
    wire  [1:0]  channelIrq;
    int          miscompares = 0;
    int          n_checks = 0;
    int          n, r, p, irqs;
    logic [21:0] ev;
    updown_timer_with_capture i_dut (.core_clk, .nrst, .clockSourceFastSel, .freeRunningEnable,
        .counterIrqEnable, .downwardDirectionEnable, .reloadThreshold, .counterClockGate,
        .counterRunEnable, .lowPowerClock, .gpioPins, .rtcValue, .channelFallingEdgeSel,
        .channelCountingModeSel, .channelIrqEnable, .channelSnapshotSource, .channelInputPinSel,
        .channelPeriodCount, .channelEventClear, .counterValue, .timerIrq, .channelCapturedValue,
        .channelEventFlag, .channelCaptureOverrun, .channelIrq);
    pin_rtc_model i_model (.core_clk, .gpioPins, .rtcValue, .lowPowerClock);
    // 40 MHz clock
    always #12.5 core_clk = ~core_clk;
    task automatic cmp(input logic [21:0] got, input logic [21:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // expected spacing of timer interrupts in core cycles
    function automatic int period(input int m, input int rl);
        return (m == 4) ? WRAP : (rl + 1) * ((m < 2) ? 1 : LP_DIV);
    endfunction
    // bounded wait for timer irq (w=0) or channel 0 flag, n counts edges
    task automatic wait_hi(input int w, input int lim);
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end while (((w == 0) ? timerIrq : channelEventFlag[0]) !== 1'b1 && n < lim);
        if (((w == 0) ? timerIrq : channelEventFlag[0]) !== 1'b1)
        begin
            miscompares++;
            wrap_up();
        end
    endtask
    // one-cycle clear pulse on both channels
    task automatic clr;
        @(posedge core_clk);
        channelEventClear <= 2'h3;
        @(posedge core_clk);
        channelEventClear <= 2'h0;
        repeat (2) @(posedge core_clk);
    endtask
    initial
    begin
        void'($urandom(94));
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        // irq spacing: fast up, fast down, slow up, slow down, free up
        for (int m = 0; m < 5; m++)
        begin
            r = $urandom_range(2, 12);
            @(posedge core_clk);
            counterRunEnable <= 1'b0;
            reloadThreshold <= 11'(r);
            clockSourceFastSel <= (m < 2 || m == 4);
            downwardDirectionEnable <= m[0];
            freeRunningEnable <= (m == 4);
            @(posedge core_clk);
            counterRunEnable <= 1'b1;
            wait_hi(0, 5000);
            wait_hi(0, 5000);
            cmp(22'(n), 22'(period(m, r)));
            // interrupt enable off: no pulses over two periods
            counterIrqEnable <= 1'b0;
            irqs = 0;
            repeat (2 * period(m, r)) @(posedge core_clk) irqs += timerIrq;
            cmp(22'(irqs), 22'h000000);
            counterIrqEnable <= 1'b1;
        end
        $display("timer test done");
        // park the counter at a known preset: down start is the reload value
        counterClockGate <= 1'b0;
        counterRunEnable <= 1'b0;
        downwardDirectionEnable <= 1'b1;
        freeRunningEnable <= 1'b0;
        reloadThreshold <= 11'($urandom);
        @(posedge core_clk);
        counterRunEnable <= 1'b1;
        // capture per snapshot source and polarity, overrun, clear
        for (int m = 0; m < 4; m++)
        begin
            p = $urandom_range(0, 11);
            @(posedge core_clk);
            channelCountingModeSel <= 2'h0;
            channelSnapshotSource <= {2{m[0]}};
            channelFallingEdgeSel <= {2{m[1]}};
            channelIrqEnable <= 2'($urandom);
            channelInputPinSel <= {2{4'(p + 1)}};
            i_model.rtcRun <= 1'b0;
            i_model.rtcValue <= 22'($urandom);
            i_model.set_pin(p, m[1]);
            clr();
            i_model.set_pin((p + 1) % 12, !gpioPins[(p + 1) % 12]);
            cmp(22'(channelEventFlag), 22'h000000);
            ev = m[0] ? rtcValue : 22'(reloadThreshold);
            i_model.set_pin(p, !m[1]);
            wait_hi(1, 20);
            cmp(channelCapturedValue[21:0], ev);
            cmp(channelCapturedValue[43:22], ev);
            cmp(22'(channelIrq), 22'(channelIrqEnable));
            i_model.rtcValue <= ~ev;
            i_model.set_pin(p, m[1]);
            i_model.set_pin(p, !m[1]);
            cmp(22'(channelCaptureOverrun), 22'h000003);
            cmp(channelCapturedValue[21:0], ev);
            clr();
            cmp(22'({channelEventFlag, channelCaptureOverrun}), 22'h000000);
        end
        $display("capture test done");
        // counting mode on a square wave, second group measured
        counterClockGate <= 1'b1;
        downwardDirectionEnable <= 1'b0;
        freeRunningEnable <= 1'b1;
        i_model.wavePin = p;
        i_model.waveOn <= 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            r = (k == 0) ? 0 : $urandom_range(1, 3);
            // one cycle in capture mode restarts the edge and cycle counters
            channelCountingModeSel <= 2'h0;
            @(posedge core_clk);
            channelCountingModeSel <= 2'h3;
            channelFallingEdgeSel <= 2'h0;
            channelPeriodCount <= {2{8'(r)}};
            clr();
            wait_hi(1, 200);
            clr();
            wait_hi(1, 200);
            cmp(channelCapturedValue[21:0], 22'((r + 1) * WAVE_P));
        end
        $display("counting test done");
        wrap_up();
    end
endmodule

bind updown_timer_with_capture timer_monitor i_mon (.core_clk, .nrst, .clockSourceFastSel,
    .freeRunningEnable, .counterIrqEnable, .downwardDirectionEnable, .reloadThreshold,
    .counterClockGate, .counterRunEnable, .counterValue, .timerIrq, .channelIrqEnable,
    .channelEventClear, .channelCapturedValue, .channelEventFlag, .channelCaptureOverrun,
    .channelIrq);

// file: tb/timer_monitor.sv
module timer_monitor (
    // timer side
    input wire        core_clk,
    input wire        nrst,
    input wire        clockSourceFastSel,
    input wire        freeRunningEnable,
    input wire        counterIrqEnable,
    input wire        downwardDirectionEnable,
    input wire [10:0] reloadThreshold,
    input wire        counterClockGate,
    input wire        counterRunEnable,
    input wire [10:0] counterValue,
    input wire        timerIrq,
    // channel side
    input wire [1:0]  channelIrqEnable,
    input wire [1:0]  channelEventClear,
    input wire [43:0] channelCapturedValue,
    input wire [1:0]  channelEventFlag,
    input wire [1:0]  channelCaptureOverrun,
    input wire [1:0]  channelIrq
);
    timeunit 1ns;
    timeprecision 100ps;
    // fast stepping qualifiers
    wire stepOn = counterRunEnable & counterClockGate & clockSourceFastSel;
    wire upOn   = stepOn & ~downwardDirectionEnable & ~freeRunningEnable;
    wire downOn = stepOn & downwardDirectionEnable;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    a_up_step: assert property (upOn && counterValue < reloadThreshold
        |=> counterValue == $past(counterValue) + 11'h001) else $error("up step");
    a_up_restart: assert property (upOn && counterValue == reloadThreshold
        |=> counterValue == 11'h000) else $error("up restart");
    a_down_step: assert property (downOn && counterValue != 11'h000
        |=> counterValue == $past(counterValue) - 11'h001) else $error("down step");
    a_down_reload: assert property (downOn && counterValue == 11'h000
        |=> counterValue == $past(reloadThreshold)) else $error("down reload");
    a_idle_preset: assert property (!counterRunEnable
        |=> counterValue == ($past(downwardDirectionEnable) ? $past(reloadThreshold) : 11'h000))
        else $error("idle preset");
    a_gate_hold: assert property (counterRunEnable && !counterClockGate
        |=> $stable(counterValue)) else $error("gate hold");
    a_irq_at_hit: assert property (timerIrq
        |-> counterValue == 11'h000 || counterValue == $past(reloadThreshold))
        else $error("irq without hit");
    a_chan_irq: assert property (channelIrq == (channelEventFlag & channelIrqEnable))
        else $error("channel irq");
    a_value_kept: assert property (channelEventFlag[0] && !channelEventClear[0]
        |=> channelEventFlag[0] && $stable(channelCapturedValue[21:0])) else $error("value moved");
    a_ovr_flag: assert property (channelCaptureOverrun[0] |-> channelEventFlag[0])
        else $error("overrun without flag");
    a_irq_gate: assert property (!counterIrqEnable |=> !timerIrq)
        else $error("timer irq while disabled");
endmodule
